// ===== pll_control_field_interlocks.sv
// Function
// - writing base select one is refused while loop enable is zero
// - clearing loop enable is refused while base select is one
// - prescaler field is write-locked while loop enabled; reset clears it
// - prescaler code P gives multiplier two to the power P
// - prescaler multiplier sets vco clock to bus clock ratio
// - vco range field is write-locked while loop enabled; reset clears it
// - vco range code E gives multiplier two to the power E
`default_nettype none
module pll_control_field_interlocks (
  // clock and reset
  input  wire logic                           clk_in,
  input  wire logic                           rst_in,
  // control register write
  input  wire logic                           wr_en_in,
  input  wire logic [pll_ctl_pkg::WORD_W-1:0] wr_data_in,
  // control state
  output var  logic                           loop_enable_out,
  output var  logic                           base_clock_source_select_out,
  output var  logic                           prescaler_select_hi_out,
  output var  logic                           prescaler_select_lo_out,
  output var  logic                           vco_range_select_hi_out,
  output var  logic                           vco_range_select_lo_out,
  // decoded multipliers
  output var  logic [pll_ctl_pkg::MULT_W-1:0] prescaler_mult_out,
  output var  logic [pll_ctl_pkg::MULT_W-1:0] vco_range_mult_out,
  // status
  output var  logic                           write_refused_out
);
  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  logic                            loop_enable_q;
  logic                            base_sel_q;
  logic [pll_ctl_pkg::FIELD_W-1:0] pre_q;
  logic [pll_ctl_pkg::FIELD_W-1:0] vpr_q;
  logic                            wr_loop;
  logic                            wr_base;
  logic [pll_ctl_pkg::FIELD_W-1:0] wr_pre;
  logic [pll_ctl_pkg::FIELD_W-1:0] wr_vpr;
  logic                            refuse_base;
  logic                            refuse_loop;
  logic                            fields_locked;
  logic                            refuse_fields;

  assign wr_loop = wr_data_in[pll_ctl_pkg::POS_LOOP_ENABLE];
  assign wr_base = wr_data_in[pll_ctl_pkg::POS_BASE_SEL];
  assign wr_pre  = wr_data_in[pll_ctl_pkg::POS_PRE_LO +: pll_ctl_pkg::FIELD_W];
  assign wr_vpr  = wr_data_in[pll_ctl_pkg::POS_VPR_LO +: pll_ctl_pkg::FIELD_W];

  // a locked field only counts as refused when the write would change it
  function automatic logic field_blocked(
    input logic                            locked,
    input logic [pll_ctl_pkg::FIELD_W-1:0] wr_val,
    input logic [pll_ctl_pkg::FIELD_W-1:0] stored
  );
    return locked && (wr_val != stored);
  endfunction

  // interlocks judge against stored state, so one write cannot switch the
  // loop on and select its clock together; base select is also refused
  // when the same write drops the loop, else base could end up on alone
  assign refuse_base   = wr_base && !(loop_enable_q && wr_loop);
  assign refuse_loop   = !wr_loop && base_sel_q;
  assign fields_locked = loop_enable_q;
  assign refuse_fields = field_blocked(fields_locked, wr_pre, pre_q)
                      || field_blocked(fields_locked, wr_vpr, vpr_q);

  // ------------------------------------------------------------
  // loop enable and base select
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      loop_enable_q <= pll_ctl_pkg::RST_LOOP_ENABLE;
    end else if (wr_en_in && !refuse_loop) begin
      loop_enable_q <= wr_loop;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      base_sel_q <= pll_ctl_pkg::RST_BASE_SEL;
    end else if (wr_en_in && !refuse_base) begin
      base_sel_q <= wr_base;
    end
  end

  // ------------------------------------------------------------
  // locked fields
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_q <= pll_ctl_pkg::RST_PRESCALER;
    end else if (wr_en_in && !fields_locked) begin
      pre_q <= wr_pre;
    end
  end

  // code 3 is stored as written; keeping it legal is up to software
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      vpr_q <= pll_ctl_pkg::RST_VCO_RANGE;
    end else if (wr_en_in && !fields_locked) begin
      vpr_q <= wr_vpr;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      write_refused_out <= 1'b0;
    end else begin
      write_refused_out <= wr_en_in && (refuse_base || refuse_loop || refuse_fields);
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign loop_enable_out              = loop_enable_q;
  assign base_clock_source_select_out = base_sel_q;
  assign prescaler_select_hi_out      = pre_q[1];
  assign prescaler_select_lo_out      = pre_q[0];
  assign vco_range_select_hi_out      = vpr_q[1];
  assign vco_range_select_lo_out      = vpr_q[0];

  // multiplier is the vco-to-bus clock ratio
  pow2_decode #(.IN_W(pll_ctl_pkg::FIELD_W), .OUT_W(pll_ctl_pkg::MULT_W)) u_pre_dec (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .exp_in   (pre_q),
    .mult_out (prescaler_mult_out)
  );

  pow2_decode #(.IN_W(pll_ctl_pkg::FIELD_W), .OUT_W(pll_ctl_pkg::MULT_W)) u_vpr_dec (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .exp_in   (vpr_q),
    .mult_out (vco_range_mult_out)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_base_set_while_off;
    wr_en_in && wr_base && !loop_enable_q;
  endsequence

  sequence s_locked_write;
    wr_en_in && loop_enable_q;
  endsequence

  AST_BASE_NEEDS_LOOP: assert property (@(posedge clk_in) disable iff (rst_in)
    s_base_set_while_off |=> base_clock_source_select_out == $past(base_sel_q))
    else $error("base select set while loop off");

  AST_BASE_IMPLIES_LOOP: assert property (@(posedge clk_in) disable iff (rst_in)
    base_clock_source_select_out |-> loop_enable_out)
    else $error("base select on with loop off");

  AST_LOOP_HELD: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_en_in && !wr_loop && base_sel_q) |=> loop_enable_out)
    else $error("loop cleared while base selected");

  AST_PRE_LOCKED: assert property (@(posedge clk_in) disable iff (rst_in)
    s_locked_write |=> $stable(pre_q))
    else $error("prescaler written while loop on");

  AST_VPR_LOCKED: assert property (@(posedge clk_in) disable iff (rst_in)
    s_locked_write |=> $stable(vpr_q))
    else $error("vco range written while loop on");

  AST_PRE_MULT: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 prescaler_mult_out == (4'h1 << $past(pre_q)))
    else $error("prescaler multiplier wrong");

  AST_VPR_MULT: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 vco_range_mult_out == (4'h1 << $past(vpr_q)))
    else $error("vco range multiplier wrong");

  AST_PARTIAL_UPDATE: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_en_in && !loop_enable_q && !wr_base) |=>
      (pre_q == $past(wr_pre)) && (loop_enable_q == $past(wr_loop)) && !base_sel_q)
    else $error("unlocked bits not updated");

  AST_UNLOCKED_WRITE: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_en_in && !loop_enable_q) |=> vpr_q == $past(wr_vpr))
    else $error("vco range write lost");

  sequence s_loop_drop_with_base;
    wr_en_in && wr_base && !wr_loop;
  endsequence

  sequence s_refused_write;
    wr_en_in && (refuse_base || refuse_loop || refuse_fields);
  endsequence

  AST_BASE_DROP_KEPT: assert property (@(posedge clk_in) disable iff (rst_in)
    s_loop_drop_with_base |=> $stable(base_sel_q))
    else $error("base select changed by a write that drops the loop");

  AST_BASE_ON_ACCEPTED: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_en_in && wr_base && wr_loop && loop_enable_q) |=> base_clock_source_select_out)
    else $error("base select refused with loop on");

  AST_LOOP_ON_ACCEPTED: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_en_in && wr_loop) |=> loop_enable_out)
    else $error("loop enable write lost");

  AST_LOOP_CLEAR_ACCEPTED: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_en_in && !wr_loop && !base_sel_q) |=> !loop_enable_out)
    else $error("loop clear lost with base off");

  AST_REFUSED_PULSE: assert property (@(posedge clk_in) disable iff (rst_in)
    s_refused_write |=> write_refused_out)
    else $error("refused write not flagged");

  AST_NO_IDLE_REFUSAL: assert property (@(posedge clk_in) disable iff (rst_in)
    !wr_en_in |=> !write_refused_out)
    else $error("refusal flagged without a write");

  AST_FIELD_EQUAL_QUIET: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_en_in && loop_enable_q && !refuse_base && !refuse_loop
      && (wr_pre == pre_q) && (wr_vpr == vpr_q)) |=> !write_refused_out)
    else $error("unchanged locked field flagged");

  AST_VPR_LEGAL: assert property (@(posedge clk_in) disable iff (rst_in)
    vpr_q <= pll_ctl_pkg::VCO_RANGE_MAX)
    else $error("vco range holds exponent three");
endmodule
`default_nettype wire

// ===== pll_ctl_pkg.sv
`default_nettype none
package pll_ctl_pkg;
  // field positions within the control write word
  localparam int unsigned POS_LOOP_ENABLE = 7;
  localparam int unsigned POS_BASE_SEL    = 4;
  localparam int unsigned POS_PRE_LO      = 0;
  localparam int unsigned POS_VPR_LO      = 2;
  localparam int unsigned WORD_W          = 8;
  localparam int unsigned FIELD_W         = 2;
  // values after reset
  localparam logic             RST_LOOP_ENABLE = 1'b0;
  localparam logic             RST_BASE_SEL    = 1'b0;
  localparam logic [FIELD_W-1:0] RST_PRESCALER = 2'h0;
  localparam logic [FIELD_W-1:0] RST_VCO_RANGE = 2'h0;
  // highest legal vco range exponent
  localparam logic [FIELD_W-1:0] VCO_RANGE_MAX = 2'h2;
  localparam int unsigned MULT_W = 4;
endpackage
`default_nettype wire

// ===== pow2_decode.sv
`default_nettype none
module pow2_decode #(
  parameter int unsigned IN_W  = 2,
  parameter int unsigned OUT_W = 4
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // exponent in, registered multiplier out
  input  wire logic [IN_W-1:0]  exp_in,
  output var  logic [OUT_W-1:0] mult_out
);
  // elaboration stops if the widest multiplier cannot be shown
  if (OUT_W < (1 << IN_W)) begin : g_width_check
    $error("pow2_decode: OUT_W too small");
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mult_out <= OUT_W'(1);
    end else begin
      mult_out <= OUT_W'(1) << exp_in;
    end
  end
endmodule
`default_nettype wire

// ===== pll_control_field_interlocks_tb.sv
`default_nettype none
module pll_control_field_interlocks_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       clk_in;
  logic       rst_in;
  logic       wr_en_in;
  logic [7:0] wr_data_in;
  logic       loop_en;
  logic       base_sel;
  logic       pre_hi;
  logic       pre_lo;
  logic       vpr_hi;
  logic       vpr_lo;
  logic       refused;
  logic [3:0] pre_mult;
  logic [3:0] vpr_mult;
  logic [5:0] st_seen;
  int         n_fail;
  int         checks;
  // rows: write word, expected {loop, base, pre, vpr}, expected refusal;
  // no row loads vco range code 3; the last row drops the loop while asking for base
  logic [7:0] wdata [11] = '{8'h10, 8'h0B, 8'h84, 8'h93, 8'h14, 8'h00,
                             8'h00, 8'h02, 8'h01, 8'h84, 8'h14};
  logic [5:0] st_exp [11] = '{6'h00, 6'h0E, 6'h21, 6'h31, 6'h31, 6'h21,
                              6'h01, 6'h08, 6'h04, 6'h21, 6'h01};
  logic       rf_exp [11] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
                              1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

  assign st_seen = {loop_en, base_sel, pre_hi, pre_lo, vpr_hi, vpr_lo};

  pll_control_field_interlocks dut_u (
    .clk_in                       (clk_in),
    .rst_in                       (rst_in),
    .wr_en_in                     (wr_en_in),
    .wr_data_in                   (wr_data_in),
    .loop_enable_out              (loop_en),
    .base_clock_source_select_out (base_sel),
    .prescaler_select_hi_out      (pre_hi),
    .prescaler_select_lo_out      (pre_lo),
    .vco_range_select_hi_out      (vpr_hi),
    .vco_range_select_lo_out      (vpr_lo),
    .prescaler_mult_out           (pre_mult),
    .vco_range_mult_out           (vpr_mult),
    .write_refused_out            (refused)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // caller sits at a falling edge; strobe drops one cycle later
  task automatic wr(input logic [7:0] d);
    wr_en_in   = 1'b1;
    wr_data_in = d;
    @(negedge clk_in);
    wr_en_in   = 1'b0;
  endtask

  task automatic reset_chk();
    chk("state", 8'h00, {2'h0, st_seen});
    chk("refused", 8'h00, {7'h0, refused});
    chk("pre_mult", 8'h01, {4'h0, pre_mult});
    chk("vpr_mult", 8'h01, {4'h0, vpr_mult});
  endtask

  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  initial begin
    repeat (2000) @(posedge clk_in);
    n_fail++;
    give_verdict();
  end

  initial begin
    rst_in     = 1'b1;
    wr_en_in   = 1'b0;
    wr_data_in = 8'h00;
    repeat (16) @(negedge clk_in);
    reset_chk();
    rst_in = 1'b0;
    $display("reset test done");
    for (int i = 0; i < 11; i++) begin
      wr(wdata[i]);
      chk("state", {2'h0, st_exp[i]}, {2'h0, st_seen});
      chk("refused", {7'h0, rf_exp[i]}, {7'h0, refused});
      @(negedge clk_in);
      chk("pre_mult", {4'h0, 4'h1 << st_exp[i][3:2]}, {4'h0, pre_mult});
      chk("vpr_mult", {4'h0, 4'h1 << st_exp[i][1:0]}, {4'h0, vpr_mult});
      $display("row %0d done", i);
    end
    // mid-run reset must drop every field, not only the interlocked bits
    rst_in = 1'b1;
    @(negedge clk_in);
    reset_chk();
    rst_in = 1'b0;
    $display("mid-run reset test done");
    // two writes with no idle cycle: loop on with fields, then base select
    wr_en_in   = 1'b1;
    wr_data_in = 8'h8B;
    @(negedge clk_in);
    wr_data_in = 8'h9B;
    @(negedge clk_in);
    wr_en_in   = 1'b0;
    chk("state", 8'h3E, {2'h0, st_seen});
    chk("refused", 8'h00, {7'h0, refused});
    @(negedge clk_in);
    chk("pre_mult", 8'h08, {4'h0, pre_mult});
    chk("vpr_mult", 8'h04, {4'h0, vpr_mult});
    $display("back-to-back test done");
    give_verdict();
  end
endmodule
`default_nettype wire
